// ==== logic/pgc_pkg.sv ====
package pgc_pkg;
  // register offsets (byte addresses on the serial register port)
  localparam logic [7:0] ADDR_CLOCK_SOURCE = 8'h14;   // clock_source_control
  localparam logic [7:0] ADDR_PG_SOURCE = 8'h15;      // power_good_source_config
  localparam logic [7:0] ADDR_PG_MODE = 8'h16;        // power_good_mode_config
  localparam logic [7:0] ADDR_POWER_GOOD_FAULT_LATCH = 8'h17;       // power_good_fault_latch
  localparam logic [7:0] ADDR_SOFTWARE_RESET_BIT = 8'h18;       // software_reset_control
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h19;    // carried-over event flags
  localparam logic [7:0] ADDR_RESET_FLAGS = 8'h1A;    // reset-occurred flag
  // clock_source_control fields
  localparam int PLL_ENABLE_BIT = 6;
  localparam int MUST_BE_ZERO_BIT = 5;
  localparam logic [4:0] FREQ_CODE_MAX = 5'h17;       // 24 MHz; above is reserved
  // power_good_source_config fields
  localparam int POLARITY_BIT = 7;
  localparam int DRIVE_TYPE_BIT = 6;
  localparam int LDO_WINDOW_BIT = 5;
  localparam int BUCK_WINDOW_BIT = 4;
  // power_good_mode_config fields
  localparam int TWARN_GATE_BIT = 2;
  localparam int FAULT_GATE_BIT = 1;
  localparam int PG_MODE_BIT = 0;
  // event flag positions
  localparam int CLK_CHANGE_FLAG_BIT = 4;
  localparam int RESET_FLAG_BIT = 0;
  // reset values
  localparam logic [7:0] RST_CLOCK_SOURCE = 8'h01;
  localparam logic [7:0] RST_PG_SOURCE = 8'h73;
  localparam logic [7:0] RST_PG_MODE = 8'h04;
endpackage

// ==== logic/pgc_ctrl.sv ====
`timescale 1ns/10ps
// Summary of operation
// - pll off selects internal rc oscillator
// - pll on uses external clock when present
// - pll on flags clock appear or disappear
// - frequency code n means n+1 mhz
// - polarity bit inverts power-good output sense
// - drive bit selects push-pull or open-drain
// - ldo window bit adds overvoltage check
// - buck window bit adds overvoltage check
// - four enable bits pick monitored sources
// - thermal warning forces power-good inactive when its gate bit is set, in either mode
// - fault gating uses latched flags not live
// - mode bit selects gated or continuous
// - latch per-source fault when an enabled source fails
// - write-one clears fault only when valid
// - software reset restores defaults and reloads
// - software reset bit clears itself
// - clock change flag latched, write-one clears
// - reset-occurred flag latched, write-one clears
module pgc_ctrl (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic REG_WR_I,              // one-cycle register write strobe
  input wire logic REG_RD_I,              // one-cycle register read strobe
  input wire logic [7:0] REG_ADDR_I,      // register address
  input wire logic [7:0] REG_WDATA_I,     // write data
  input wire logic EXT_CLOCK_PRESENT_I,   // detector output for ext_clock_input (async)
  input wire logic [3:0] UV_OK_I,         // per-source undervoltage ok (ldo1,ldo0,buck1,buck0)
  input wire logic [3:0] OV_OK_I,         // per-source overvoltage ok
  input wire logic THERMAL_WARN_I,        // thermal warning flag (async)
  input wire logic PG_GATE_I,             // gating window for gated mode (async)
  output logic [7:0] REG_RDATA_O,         // read data, valid cycle after read strobe
  output logic USE_EXT_CLOCK_O,           // switching clock taken from external input
  output logic PLL_ENABLE_O,              // pll powered
  output logic [4:0] EXT_CLOCK_FREQ_CODE_O,
  output logic POWER_GOOD_OUTPUT_O,       // pin output level
  output logic POWER_GOOD_OUTPUT_OE_O,    // pin output enable
  output logic OTP_RELOAD_O,              // one-cycle pulse: reload programmed settings
  output logic SERIAL_RESET_O             // one-cycle pulse: reset serial interface logic
);

  typedef struct packed {
    logic [7:0] clk_src;      // clock_source_control
    logic [7:0] pg_src;       // power_good_source_config
    logic [7:0] pg_mode;      // power_good_mode_config
    logic [3:0] fault;        // power_good_fault_latch
    logic clk_chg_flag;       // clock appeared or disappeared
    logic rst_flag;           // reset occurred
    logic [1:0] ext_sync;     // synchroniser for clock present
    logic [1:0] tw_sync;      // synchroniser for thermal warning
    logic [1:0] gate_sync;    // synchroniser for gate window
    logic [3:0] uv_s1;        // first stage, undervoltage
    logic [3:0] uv_s2;
    logic [3:0] ov_s1;        // first stage, overvoltage
    logic [3:0] ov_s2;
    logic ext_prev;           // last synchronised clock-present level
    logic [1:0] warm;         // synchroniser fill after reset; latching waits for it
    logic sw_rst;             // pending software reset (self clearing)
    logic [7:0] rdata;
    logic use_ext;
    logic pll_en;
    logic pg_out;
    logic pg_oe;
    logic otp_reload;
    logic ser_reset;
  } pgc_state_t;

  pgc_state_t s_q; // registered state
  pgc_state_t s_d; // next state

  // per-source validity under the window setting
  function automatic logic [3:0] pgc_src_valid(input logic [3:0] uv, input logic [3:0] ov,
                                               input logic ldo_win, input logic buck_win);
    logic [3:0] chk;
    chk = {ldo_win, ldo_win, buck_win, buck_win};
    pgc_src_valid = uv & (ov | ~chk);
  endfunction

  logic [3:0] enables;      // monitored source enables
  logic [3:0] valid_now;    // synchronised validity per source
  logic [3:0] failing;      // enabled sources currently invalid
  logic live_good;          // and of enabled sources
  logic good;               // final valid before polarity
  logic ext_now;            // synchronised clock present

  // decide state and outputs
  always_comb begin
    s_d = s_q;
    enables = s_q.pg_src[3:0];
    ext_now = s_q.ext_sync[1];
    valid_now = pgc_src_valid(s_q.uv_s2, s_q.ov_s2, s_q.pg_src[pgc_pkg::LDO_WINDOW_BIT],
                              s_q.pg_src[pgc_pkg::BUCK_WINDOW_BIT]);
    failing = enables & ~valid_now;
    live_good = &(valid_now | ~enables);
    // with fault gating, latched flags hold power-good off until each is cleared; otherwise live validity
    if (s_q.pg_mode[pgc_pkg::FAULT_GATE_BIT]) begin
      good = ~|s_q.fault;
    end else begin
      good = live_good;
    end
    if (s_q.pg_mode[pgc_pkg::TWARN_GATE_BIT] && s_q.tw_sync[1]) begin
      good = 1'b0;
    end
    // gated mode only reports during the gate window; continuous always
    if (!s_q.pg_mode[pgc_pkg::PG_MODE_BIT] && !s_q.gate_sync[1]) begin
      good = 1'b0;
    end
    // synchronisers: first stages read only by second stages
    s_d.ext_sync = {s_q.ext_sync[0], EXT_CLOCK_PRESENT_I};
    s_d.tw_sync = {s_q.tw_sync[0], THERMAL_WARN_I};
    s_d.gate_sync = {s_q.gate_sync[0], PG_GATE_I};
    s_d.uv_s1 = UV_OK_I;
    s_d.uv_s2 = s_q.uv_s1;
    s_d.ov_s1 = OV_OK_I;
    s_d.ov_s2 = s_q.ov_s1;
    s_d.ext_prev = ext_now;
    s_d.warm = {s_q.warm[0], 1'b1};
    s_d.otp_reload = 1'b0;
    s_d.ser_reset = 1'b0;
    s_d.sw_rst = 1'b0;
    s_d.rdata = 8'h00;
    // clock source selection
    s_d.pll_en = s_q.clk_src[pgc_pkg::PLL_ENABLE_BIT];
    s_d.use_ext = s_q.clk_src[pgc_pkg::PLL_ENABLE_BIT] & ext_now;
    // output driver: open-drain only pulls low
    s_d.pg_out = good ^ s_q.pg_src[pgc_pkg::POLARITY_BIT];
    s_d.pg_oe = ~s_q.pg_src[pgc_pkg::DRIVE_TYPE_BIT] | ~s_d.pg_out;
    // register writes; hardware sets are applied after, so sets win
    if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        pgc_pkg::ADDR_CLOCK_SOURCE: begin
          // bit five kept as written; host must keep it zero
          s_d.clk_src = REG_WDATA_I;
        end
        pgc_pkg::ADDR_PG_SOURCE: begin
          s_d.pg_src = REG_WDATA_I;
        end
        pgc_pkg::ADDR_PG_MODE: begin
          s_d.pg_mode = REG_WDATA_I;
        end
        pgc_pkg::ADDR_POWER_GOOD_FAULT_LATCH: begin
          // a flag only clears while its source is valid now
          s_d.fault = s_q.fault & ~(REG_WDATA_I[3:0] & valid_now);
        end
        pgc_pkg::ADDR_SOFTWARE_RESET_BIT: begin
          s_d.sw_rst = REG_WDATA_I[0];
        end
        pgc_pkg::ADDR_EVENT_FLAGS: begin
          if (REG_WDATA_I[pgc_pkg::CLK_CHANGE_FLAG_BIT]) begin
            s_d.clk_chg_flag = 1'b0;
          end
        end
        pgc_pkg::ADDR_RESET_FLAGS: begin
          if (REG_WDATA_I[pgc_pkg::RESET_FLAG_BIT]) begin
            s_d.rst_flag = 1'b0;
          end
        end
        default: begin
          // unmapped address: write ignored
        end
      endcase
    end
    // reads return the state before this cycle's write
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        pgc_pkg::ADDR_CLOCK_SOURCE: s_d.rdata = s_q.clk_src;
        pgc_pkg::ADDR_PG_SOURCE: s_d.rdata = s_q.pg_src;
        pgc_pkg::ADDR_PG_MODE: s_d.rdata = s_q.pg_mode;
        pgc_pkg::ADDR_POWER_GOOD_FAULT_LATCH: s_d.rdata = {4'h0, s_q.fault};
        pgc_pkg::ADDR_SOFTWARE_RESET_BIT: s_d.rdata = {7'h00, s_q.sw_rst};
        pgc_pkg::ADDR_EVENT_FLAGS: s_d.rdata = {3'h0, s_q.clk_chg_flag, 4'h0};
        pgc_pkg::ADDR_RESET_FLAGS: s_d.rdata = {7'h00, s_q.rst_flag};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // hardware sets win over a same-cycle clear
    // the monitor stages reset to zero; latching them before they fill would log false faults
    if (s_q.warm[1]) begin
      s_d.fault = s_d.fault | failing;
    end
    if (s_q.clk_src[pgc_pkg::PLL_ENABLE_BIT] && (ext_now != s_q.ext_prev)) begin
      s_d.clk_chg_flag = 1'b1;
    end
    // software reset: defaults back, reload and serial reset pulses
    if (s_q.sw_rst) begin
      s_d.clk_src = pgc_pkg::RST_CLOCK_SOURCE;
      s_d.pg_src = pgc_pkg::RST_PG_SOURCE;
      s_d.pg_mode = pgc_pkg::RST_PG_MODE;
      s_d.fault = 4'h0;
      s_d.clk_chg_flag = 1'b0;
      s_d.rst_flag = 1'b1;
      s_d.otp_reload = 1'b1;
      s_d.ser_reset = 1'b1;
    end
  end

  // state register; synchronous active-low reset
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      s_q <= '0;
      s_q.clk_src <= pgc_pkg::RST_CLOCK_SOURCE;
      s_q.pg_src <= pgc_pkg::RST_PG_SOURCE;
      s_q.pg_mode <= pgc_pkg::RST_PG_MODE;
      s_q.pg_out <= 1'b1; // inactive low with polarity 0 is pulled via od; keep released
      s_q.pg_oe <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA_O = s_q.rdata;
  assign USE_EXT_CLOCK_O = s_q.use_ext;
  assign PLL_ENABLE_O = s_q.pll_en;
  assign EXT_CLOCK_FREQ_CODE_O = s_q.clk_src[4:0];
  assign POWER_GOOD_OUTPUT_O = s_q.pg_out;
  assign POWER_GOOD_OUTPUT_OE_O = s_q.pg_oe;
  assign OTP_RELOAD_O = s_q.otp_reload;
  assign SERIAL_RESET_O = s_q.ser_reset;

endmodule

// ==== bench/pgc_ctrl_chk.sv ====
`timescale 1ns/10ps
module pgc_ctrl_chk (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic EXT_CLOCK_PRESENT_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic USE_EXT_CLOCK_O,
  input wire logic PLL_ENABLE_O,
  input wire logic [4:0] EXT_CLOCK_FREQ_CODE_O,
  input wire logic POWER_GOOD_OUTPUT_O,
  input wire logic POWER_GOOD_OUTPUT_OE_O,
  input wire logic OTP_RELOAD_O,
  input wire logic SERIAL_RESET_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  logic swr_hit; // software reset request seen at the register port
  logic od_q; // shadow of the drive type bit; goes open-drain early on a reset so it never lags
  assign swr_hit = REG_WR_I && REG_ADDR_I == pgc_pkg::ADDR_SOFTWARE_RESET_BIT && REG_WDATA_I[0];
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I || swr_hit) od_q <= 1'b1;
    else if (REG_WR_I && REG_ADDR_I == pgc_pkg::ADDR_PG_SOURCE) od_q <= REG_WDATA_I[pgc_pkg::DRIVE_TYPE_BIT];
  end
  sequence s_swr_req;
    swr_hit;
  endsequence
  sequence s_swr_act;
    ##2 OTP_RELOAD_O && SERIAL_RESET_O;
  endsequence
  a_swr_pulse_due: assert property (s_swr_req |-> s_swr_act) else $error("reset pulses late");
  a_swr_pulse_once: assert property (OTP_RELOAD_O |-> SERIAL_RESET_O ##1 !OTP_RELOAD_O) else $error("pulse long");
  a_swr_defaults_back: assert property (OTP_RELOAD_O |=> !PLL_ENABLE_O && EXT_CLOCK_FREQ_CODE_O == 5'h01)
    else $error("clock reg not default");
  a_swr_bit_clear: assert property (REG_RD_I && REG_ADDR_I == pgc_pkg::ADDR_SOFTWARE_RESET_BIT && !REG_WR_I && !$past(REG_WR_I)
    |=> !REG_RDATA_O[0]) else $error("reset bit stuck");
  a_rdata_idle_zero: assert property (!REG_RD_I |=> REG_RDATA_O == 8'h00) else $error("stray read data");
  a_pll_off_rc: assert property (!PLL_ENABLE_O [*2] |-> !USE_EXT_CLOCK_O) else $error("ext clock with pll off");
  a_pll_ext_follow: assert property ((PLL_ENABLE_O && EXT_CLOCK_PRESENT_I) [*4] |-> USE_EXT_CLOCK_O)
    else $error("ext clock not taken");
  a_od_no_high: assert property (od_q [*3] |-> !(POWER_GOOD_OUTPUT_OE_O && POWER_GOOD_OUTPUT_O))
    else $error("open drain drives high");
  a_pp_always_on: assert property (!od_q [*3] |-> POWER_GOOD_OUTPUT_OE_O) else $error("push-pull not driven");
endmodule
bind pgc_ctrl pgc_ctrl_chk u_pgc_ctrl_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .EXT_CLOCK_PRESENT_I(EXT_CLOCK_PRESENT_I),
  .REG_RDATA_O(REG_RDATA_O), .USE_EXT_CLOCK_O(USE_EXT_CLOCK_O), .PLL_ENABLE_O(PLL_ENABLE_O),
  .EXT_CLOCK_FREQ_CODE_O(EXT_CLOCK_FREQ_CODE_O), .POWER_GOOD_OUTPUT_O(POWER_GOOD_OUTPUT_O),
  .POWER_GOOD_OUTPUT_OE_O(POWER_GOOD_OUTPUT_OE_O), .OTP_RELOAD_O(OTP_RELOAD_O), .SERIAL_RESET_O(SERIAL_RESET_O));

// ==== bench/pgc_host.sv ====
`timescale 1ns/10ps
module pgc_host (
  input wire logic clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // idle bus from time zero, so no unknown strobe reaches the block after reset
  initial begin
    {wr_o, rd_o, addr_o, wdata_o} = 18'h00000;
  end
  // one strobed transfer; released address and data lines show the inverse so a stale value is never trusted
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = (a == pgc_pkg::ADDR_CLOCK_SOURCE) ? (d & 8'hDF) : d;
    @(posedge clk_i) #1;
    {wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~addr_o, ~wdata_o};
  endtask
endmodule

// ==== bench/pgc_ctrl_tb.sv ====
`timescale 1ns/10ps
module pgc_ctrl_tb;
  logic clk = 0, rst_n = 0, wr, rd, pres = 0, twarn = 0, gate = 1, pend = 0, use_ext, pll, pg, oe;
  logic [7:0] addr, wdata, rdata; // addr and wdata driven by the host model; rdata driven by the block
  logic [3:0] uv = 4'hF, ov = 4'hF;
  logic [4:0] code, code_v;
  logic [7:0] exp_q[$]; // expected read data, oldest first
  logic [15:0] tbl[8] = '{16'h1401, 16'h1573, 16'h1604, 16'h1700, 16'h1800, 16'h1900, 16'h1A00, 16'h3000};
  int err_count = 0, compares = 0, seed = 32'h075cd2d7;
  initial forever #4 clk = ~clk;
  pgc_host u_pgc_host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
  pgc_ctrl u_pgc_ctrl (.CLK_I(clk), .RESETN_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .EXT_CLOCK_PRESENT_I(pres), .UV_OK_I(uv), .OV_OK_I(ov), .THERMAL_WARN_I(twarn),
    .PG_GATE_I(gate), .REG_RDATA_O(rdata), .USE_EXT_CLOCK_O(use_ext), .PLL_ENABLE_O(pll),
    .EXT_CLOCK_FREQ_CODE_O(code), .POWER_GOOD_OUTPUT_O(pg), .POWER_GOOD_OUTPUT_OE_O(oe),
    .OTP_RELOAD_O(), .SERIAL_RESET_O());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_pgc_host.xfer(1'b1, a, d);
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_pgc_host.xfer(1'b0, a, 8'h00);
  endtask
  // pin level and enable after the two-flop input path has settled
  task automatic pin(input logic l, input logic e);
    repeat (5) @(negedge clk);
    chk({6'h00, oe, pg}, {6'h00, e, l});
  endtask
  task close_out;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // read data stands one cycle after the strobe; compare it with the oldest note
  always @(negedge clk) begin
    if (pend) chk(rdata, exp_q.pop_front());
    pend = rd;
  end
  initial begin
    #200000 err_count++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    foreach (tbl[i]) r(tbl[i][15:8], tbl[i][7:0]);
    code_v = 5'($unsigned($random(seed)) % 24);
    w(8'h14, {3'b011, code_v});
    r(8'h14, {3'b010, code_v});
    pres = 1;
    pin(1, 0);
    chk({use_ext, pll, 1'b0, code}, {3'b110, code_v});
    r(8'h19, 8'h10);
    w(8'h19, 8'h10);
    r(8'h19, 8'h00);
    pres = 0;
    pin(1, 0);
    chk({7'h00, use_ext}, 8'h00);
    r(8'h19, 8'h10);
    w(8'h19, 8'h10);
    w(8'h14, 8'h00);
    pres = 1;
    pin(1, 0);
    chk({6'h00, use_ext, pll}, 8'h00);
    r(8'h19, 8'h00);
    w(8'h15, 8'h03);
    w(8'h16, 8'h01);
    pin(1, 1);
    ov = 4'hD;
    pin(1, 1);
    w(8'h15, 8'h13);
    pin(0, 1);
    ov = 4'hF;
    pin(1, 1);
    r(8'h17, 8'h02);
    w(8'h17, 8'h02);
    r(8'h17, 8'h00);
    uv = 4'hE;
    pin(0, 1);
    w(8'h17, 8'h01);
    r(8'h17, 8'h01);
    uv = 4'hF;
    pin(1, 1);
    w(8'h17, 8'h01);
    r(8'h17, 8'h00);
    uv = 4'h7;
    pin(1, 1);
    w(8'h15, 8'h0B);
    pin(0, 1);
    uv = 4'hF;
    ov = 4'h7;
    pin(1, 1);
    w(8'h15, 8'h2B);
    pin(0, 1);
    ov = 4'hF;
    w(8'h16, 8'h03);
    pin(0, 1);
    w(8'h17, 8'h08);
    pin(1, 1);
    w(8'h15, 8'h83);
    pin(0, 1);
    w(8'h15, 8'h43);
    w(8'h16, 8'h05);
    pin(1, 0);
    twarn = 1;
    pin(0, 1);
    w(8'h16, 8'h01);
    pin(1, 0);
    gate = 0;
    pin(1, 0);
    w(8'h16, 8'h00);
    pin(0, 1);
    w(8'h18, 8'h01);
    r(8'h18, 8'h00);
    r(8'h15, 8'h73);
    r(8'h1A, 8'h01);
    w(8'h1A, 8'h01);
    r(8'h1A, 8'h00);
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule
